// File: fmlc_consts.svh
// Offsets, field positions, reset values and timing counts of the modem and meter control bank
`ifndef FMLC_CONSTS_SVH
`define FMLC_CONSTS_SVH
// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define CMD_WRITE_BIT 7
`define CMD_ADDR_MSB 6
`define CMD_ADDR_W 7
// ----------------------------------------
// Register offsets (command bits 6:0)
// ----------------------------------------
`define OFS_COEF_SEL 7'h00
`define OFS_MODEM_CTRL 7'h30
`define OFS_RESULT_LOW 7'h31
`define OFS_RESULT_HIGH 7'h32
`define OFS_WINDOW 7'h33
`define OFS_METER_CTRL 7'h34
`define OFS_LOOP_PLL 7'h35
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODEM_GO_BIT 0
`define MODEM_HOLD_BIT 1
`define MODEM_SPEC_BIT 2
`define MODEM_EN_BIT 3
`define MODEM_CHAN_LSB 4
`define METER_CHAN_LSB 0
`define METER_MODE_BIT 2
`define METER_EN_BIT 3
`define LOOP_FIELD_W 5
`define PLL_SLEEP_BIT 5
`define COEF_HPF_BIT 3
`define READY_BIT 0
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_CHAN 2'h0
`define MSG_LEN_MAX 8'h40
`define FRAME_TIME_US 125
`endif

// File: fmlc_pkg.sv
// Types shared by the modem and meter control bank
package fmlc_pkg;
  // Modem sequencer phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEIZE = 3'b001,
    ST_MARK = 3'b010,
    ST_DATA = 3'b011,
    ST_HOLD = 3'b100,
    ST_DONE = 3'b101
  } modem_state_t;
endpackage

// File: fsk_meter_loop_control_regs.sv
// Modem transmit control, level meter, loopback/PLL and coefficient source register bank
// Summary of operation
// R1 - Modem channel chosen by two-bit select
// R2 - Modem runs only while enable bit set
// R3 - Variant bit: 0 North American, 1 British
// R4 - Hold-marking clear: mute after word data
// R5 - Hold-marking set: send ones until restarted
// R6 - Software sets go; hardware clears at end
// R7 - All lengths zero: go clears immediately
// R8 - Low result bit 0 is ready flag
// R9 - Reading high byte clears ready flag
// R10 - High byte holds upper meter result bits
// R11 - Window zero: sample passes straight through
// R12 - Window N: sample over N frames
// R13 - Meter runs only while enable set
// R14 - Message mode copies compressed samples
// R15 - Meter mode measures linear samples
// R16 - Meter channel chosen by two-bit field
// R17 - Sleep bit powers down PLL, clocks
// R18 - Five independent loopback enables, default off
// R19 - Coefficient bits pick default or RAM
// R20 - Coefficient bit 3 enables high-pass filter
// R21 - Software keeps impedance bits equal
// R22 - Command bit 7 is read/write flag
// R23 - Seizure sends setting count of 01 pairs
// R24 - Message length capped at 64
// R25 - Go ignored while modem disabled
`timescale 1ns/1ps
`include "fmlc_consts.svh"
module fsk_meter_loop_control_regs #(
  parameter int BIT_CYCLES = 16667,
  parameter int CLK_MHZ = 20,
  parameter int FRAME_CYCLES = `FRAME_TIME_US * CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] cmd_wdata,
  input wire logic [1:0] cmd_channel,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic [7:0] seizure_length,
  input wire logic [7:0] marking_length,
  input wire logic [7:0] message_length,
  input wire logic msg_bit,
  output logic msg_bit_take,
  output logic modem_tx_bit,
  output logic modem_tx_active,
  output logic [1:0] modem_channel_sel,
  output logic modem_enable_bit,
  output logic spec_variant_sel,
  output logic hold_marking_after_send,
  output logic modem_transmit_go,
  input wire logic sample_valid,
  input wire logic [63:0] ch_sample,
  output logic [7:0] meter_result_low,
  output logic [7:0] meter_result_high,
  output logic [7:0] meter_window_count,
  output logic meter_enable_bit,
  output logic meter_mode,
  output logic [1:0] meter_channel,
  output logic pll_sleep,
  output logic [`LOOP_FIELD_W-1:0] loop_enables,
  output logic [31:0] coef_source_flat
);
  // Elaboration check on the bit divider range
  if (BIT_CYCLES < 2 || BIT_CYCLES > 65535) begin : g_bit_cycles_bad
    $error("BIT_CYCLES out of range");
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Address part of a command byte
  function automatic logic [`CMD_ADDR_W-1:0] cmd_addr(input logic [7:0] b);
    cmd_addr = b[`CMD_ADDR_MSB:0];
  endfunction

  logic is_wr, is_rd;
  logic [`CMD_ADDR_W-1:0] addr;
  assign is_wr = cmd_valid & cmd_byte[`CMD_WRITE_BIT]; // [R22]
  assign is_rd = cmd_valid & ~cmd_byte[`CMD_WRITE_BIT]; // [R22]
  assign addr = cmd_addr(cmd_byte);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] modem_ctrl_r, modem_ctrl_nxt;
  logic [7:0] window_r, window_nxt;
  logic [3:0] meter_ctrl_r, meter_ctrl_nxt;
  logic [5:0] loop_r, loop_nxt;
  logic [7:0] coef_r [4];
  logic [7:0] coef_nxt [4];
  logic go_clear, go_set;
  logic [7:0] wl_eff;
  logic all_zero;

  // Message length saturates at the maximum
  assign wl_eff = (message_length > `MSG_LEN_MAX) ? `MSG_LEN_MAX : message_length; // [R24]
  assign all_zero = (seizure_length == 8'h00) && (marking_length == 8'h00) && (wl_eff == 8'h00);

  // Register write paths; a fresh write of the modem control register wins over the hardware clear of go
  always_comb begin
    modem_ctrl_nxt = modem_ctrl_r;
    window_nxt = window_r;
    meter_ctrl_nxt = meter_ctrl_r;
    loop_nxt = loop_r;
    go_set = 1'b0;
    for (int i = 0; i < 4; i++) begin
      coef_nxt[i] = coef_r[i];
    end
    if (go_clear) begin
      modem_ctrl_nxt[`MODEM_GO_BIT] = 1'b0; // [R6]
    end
    if (is_wr) begin
      case (addr)
        `OFS_MODEM_CTRL: begin
          modem_ctrl_nxt = {2'h0, cmd_wdata[5:1], 1'b0};
          // Go only latches while enabled and with something to send
          go_set = cmd_wdata[`MODEM_GO_BIT] & cmd_wdata[`MODEM_EN_BIT]; // [R25]
          modem_ctrl_nxt[`MODEM_GO_BIT] = go_set & ~all_zero; // [R7]
        end
        `OFS_WINDOW: window_nxt = cmd_wdata;
        `OFS_METER_CTRL: meter_ctrl_nxt = cmd_wdata[3:0];
        `OFS_LOOP_PLL: loop_nxt = cmd_wdata[5:0];
        `OFS_COEF_SEL: coef_nxt[cmd_channel] = cmd_wdata; // [R19] [R20]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modem_ctrl_r <= `RST_BYTE;
      window_r <= `RST_BYTE;
      meter_ctrl_r <= 4'h0;
      loop_r <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        coef_r[i] <= `RST_BYTE;
      end
    end else begin
      modem_ctrl_r <= modem_ctrl_nxt;
      window_r <= window_nxt;
      meter_ctrl_r <= meter_ctrl_nxt;
      loop_r <= loop_nxt;
      for (int i = 0; i < 4; i++) begin
        coef_r[i] <= coef_nxt[i];
      end
    end
  end

  // Control fields straight from their flops
  assign modem_channel_sel = modem_ctrl_r[`MODEM_CHAN_LSB+1:`MODEM_CHAN_LSB]; // [R1]
  assign modem_enable_bit = modem_ctrl_r[`MODEM_EN_BIT]; // [R2]
  assign spec_variant_sel = modem_ctrl_r[`MODEM_SPEC_BIT]; // [R3]
  assign hold_marking_after_send = modem_ctrl_r[`MODEM_HOLD_BIT];
  assign modem_transmit_go = modem_ctrl_r[`MODEM_GO_BIT];
  assign meter_window_count = window_r;
  assign meter_enable_bit = meter_ctrl_r[`METER_EN_BIT];
  assign meter_mode = meter_ctrl_r[`METER_MODE_BIT];
  assign meter_channel = meter_ctrl_r[`METER_CHAN_LSB+1:`METER_CHAN_LSB]; // [R16]
  assign pll_sleep = loop_r[`PLL_SLEEP_BIT]; // [R17]
  assign loop_enables = loop_r[`LOOP_FIELD_W-1:0]; // [R18]

  // Flatten per-channel coefficient sources
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_coef
      assign coef_source_flat[g*8 +: 8] = coef_r[g];
    end
  endgenerate

  // ----------------------------------------
  // Modem sequencer
  // ----------------------------------------
  fmlc_pkg::modem_state_t st_r, st_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [15:0] div_r, div_nxt;
  logic tx_bit_r, tx_bit_nxt, act_r, act_nxt, take_r, take_nxt;
  logic tick, run;

  // Bits to send in a phase
  function automatic logic [8:0] phase_len(input fmlc_pkg::modem_state_t s, input logic [7:0] sl,
                                           input logic [7:0] ml, input logic [7:0] wl);
    case (s)
      fmlc_pkg::ST_SEIZE: phase_len = {sl, 1'b0}; // [R23]
      fmlc_pkg::ST_MARK: phase_len = {1'b0, ml};
      fmlc_pkg::ST_DATA: phase_len = {1'b0, wl};
      default: phase_len = 9'h000;
    endcase
  endfunction

  // Bit sent while a phase counter holds the given value; even seizure counts send 0
  function automatic logic phase_bit(input fmlc_pkg::modem_state_t s, input logic [8:0] c, input logic d);
    case (s)
      fmlc_pkg::ST_SEIZE: phase_bit = c[0]; // [R23]
      fmlc_pkg::ST_MARK: phase_bit = 1'b1;
      fmlc_pkg::ST_DATA: phase_bit = d;
      default: phase_bit = 1'b0;
    endcase
  endfunction

  // First non-empty phase after the given one
  function automatic fmlc_pkg::modem_state_t next_phase(input fmlc_pkg::modem_state_t s,
      input logic [7:0] sl, input logic [7:0] ml, input logic [7:0] wl);
    next_phase = fmlc_pkg::ST_DONE;
    if (s == fmlc_pkg::ST_IDLE && sl != 8'h00) next_phase = fmlc_pkg::ST_SEIZE;
    else if ((s == fmlc_pkg::ST_IDLE || s == fmlc_pkg::ST_SEIZE) && ml != 8'h00) next_phase = fmlc_pkg::ST_MARK;
    else if (s != fmlc_pkg::ST_DATA && wl != 8'h00) next_phase = fmlc_pkg::ST_DATA;
  endfunction

  assign run = modem_enable_bit & ~pll_sleep;
  assign tick = (div_r == 16'(BIT_CYCLES - 1));

  // Phase walk on bit ticks; end of data clears go and picks mute or hold
  always_comb begin
    fmlc_pkg::modem_state_t np;
    np = fmlc_pkg::ST_DONE;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    go_clear = 1'b0;
    take_nxt = 1'b0;
    tx_bit_nxt = tx_bit_r;
    if (!modem_enable_bit) begin
      st_nxt = fmlc_pkg::ST_IDLE; // [R2]
      go_clear = 1'b1;
      div_nxt = 16'h0000;
    end else if (!run) begin
      div_nxt = div_r;
    end else begin
      case (st_r)
        fmlc_pkg::ST_IDLE, fmlc_pkg::ST_HOLD: begin
          if (modem_transmit_go) begin
            np = next_phase(fmlc_pkg::ST_IDLE, seizure_length, marking_length, wl_eff);
            st_nxt = np;
            cnt_nxt = phase_len(np, seizure_length, marking_length, wl_eff);
            tx_bit_nxt = phase_bit(np, cnt_nxt, msg_bit); // [R23]
            take_nxt = (np == fmlc_pkg::ST_DATA);
            div_nxt = 16'h0000;
          end else if (st_r == fmlc_pkg::ST_HOLD && hold_marking_after_send) begin
            tx_bit_nxt = 1'b1; // [R5]
          end else begin
            st_nxt = fmlc_pkg::ST_IDLE; // [R4]
          end
        end
        fmlc_pkg::ST_SEIZE, fmlc_pkg::ST_MARK, fmlc_pkg::ST_DATA: begin
          if (tick) begin
            np = st_r;
            cnt_nxt = cnt_r - 9'h001;
            if (cnt_r == 9'h001) begin
              np = next_phase(st_r, seizure_length, marking_length, wl_eff);
              cnt_nxt = phase_len(np, seizure_length, marking_length, wl_eff);
            end
            st_nxt = np;
            // Next bit stands for the whole coming bit period
            tx_bit_nxt = phase_bit(np, cnt_nxt, msg_bit); // [R23]
            take_nxt = (np == fmlc_pkg::ST_DATA);
          end
        end
        fmlc_pkg::ST_DONE: begin
          go_clear = 1'b1; // [R6]
          st_nxt = hold_marking_after_send ? fmlc_pkg::ST_HOLD : fmlc_pkg::ST_IDLE; // [R4] [R5]
        end
        default: st_nxt = fmlc_pkg::ST_IDLE;
      endcase
    end
    act_nxt = (st_nxt != fmlc_pkg::ST_IDLE) && (st_nxt != fmlc_pkg::ST_DONE);
    if (!act_nxt) begin
      tx_bit_nxt = 1'b0; // [R4]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= fmlc_pkg::ST_IDLE;
      cnt_r <= 9'h000;
      div_r <= 16'h0000;
      tx_bit_r <= 1'b0;
      act_r <= 1'b0;
      take_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      tx_bit_r <= tx_bit_nxt;
      act_r <= act_nxt;
      take_r <= take_nxt;
    end
  end

  assign modem_tx_bit = tx_bit_r;
  assign modem_tx_active = act_r;
  assign msg_bit_take = take_r;

  // ----------------------------------------
  // Level meter
  // ----------------------------------------
  logic [15:0] res_r, res_nxt;
  logic [14:0] peak_r, peak_nxt;
  logic [7:0] frames_r, frames_nxt;
  logic rdy_r, rdy_nxt;
  logic [15:0] smp;
  logic [14:0] mag;
  logic hi_read;

  assign smp = ch_sample[meter_channel*16 +: 16]; // [R16]
  assign mag = smp[15] ? 15'(~smp + 16'h0001) : smp[14:0];
  assign hi_read = is_rd && (addr == `OFS_RESULT_HIGH);

  // Result capture; a new result held off while the old one awaits reading
  always_comb begin
    res_nxt = res_r;
    peak_nxt = peak_r;
    frames_nxt = frames_r;
    rdy_nxt = rdy_r;
    if (hi_read) begin
      rdy_nxt = 1'b0; // [R9]
    end
    if (!meter_enable_bit) begin
      peak_nxt = 15'h0000; // [R13]
      frames_nxt = 8'h00;
    end else if (sample_valid && !pll_sleep) begin
      if (window_r == 8'h00) begin
        if (!rdy_r) begin
          res_nxt = meter_mode ? {mag, 1'b0} : {smp[7:0], 8'h00}; // [R11] [R14]
          rdy_nxt = 1'b1; // [R8]
        end
      end else begin
        peak_nxt = (mag > peak_r) ? mag : peak_r; // [R15]
        frames_nxt = frames_r + 8'h01;
        if (frames_r + 8'h01 == window_r) begin
          if (!rdy_r) begin
            res_nxt = meter_mode ? {peak_nxt, 1'b0} : {smp[7:0], 8'h00}; // [R12] [R14]
            rdy_nxt = 1'b1;
          end
          peak_nxt = 15'h0000;
          frames_nxt = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_r <= 16'h0000;
      peak_r <= 15'h0000;
      frames_r <= 8'h00;
      rdy_r <= 1'b0;
    end else begin
      res_r <= res_nxt;
      peak_r <= peak_nxt;
      frames_r <= frames_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign meter_result_low = {res_r[7:1], rdy_r}; // [R8]
  assign meter_result_high = res_r[15:8]; // [R10]

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r;

  // Read mux; unmapped offsets return zero
  always_comb begin
    rd_data_nxt = 8'h00;
    case (addr)
      `OFS_MODEM_CTRL: rd_data_nxt = modem_ctrl_r;
      `OFS_RESULT_LOW: rd_data_nxt = meter_result_low;
      `OFS_RESULT_HIGH: rd_data_nxt = meter_result_high;
      `OFS_WINDOW: rd_data_nxt = window_r;
      `OFS_METER_CTRL: rd_data_nxt = {4'h0, meter_ctrl_r};
      `OFS_LOOP_PLL: rd_data_nxt = {2'h0, loop_r};
      `OFS_COEF_SEL: rd_data_nxt = coef_r[cmd_channel];
      default: rd_data_nxt = 8'h00;
    endcase
    if (!is_rd) begin
      rd_data_nxt = rd_data_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_r <= `RST_BYTE;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= is_rd;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence go_write_s;
    is_wr && addr == `OFS_MODEM_CTRL && cmd_wdata[`MODEM_GO_BIT];
  endsequence

  zero_len_go_a: assert property (go_write_s and all_zero |=> !modem_transmit_go) // [R7]
    else $error("go stayed set with all lengths zero");
  disabled_go_a: assert property (go_write_s and !cmd_wdata[`MODEM_EN_BIT] |=> !modem_transmit_go) // [R25]
    else $error("go latched while modem disabled");
  done_clears_go_a: assert property (st_r == fmlc_pkg::ST_DONE && modem_enable_bit |=> !modem_transmit_go) // [R6]
    else $error("go not cleared at end of data");
  hold_ones_a: assert property (st_r == fmlc_pkg::ST_HOLD && st_nxt == fmlc_pkg::ST_HOLD |=> modem_tx_bit && modem_tx_active) // [R5]
    else $error("hold phase not sending ones");
  mute_after_a: assert property (st_r == fmlc_pkg::ST_DONE && !hold_marking_after_send |=> !modem_tx_active ##1 !modem_tx_bit) // [R4]
    else $error("output not muted after data");
  seize_alt_a: assert property (st_r == fmlc_pkg::ST_SEIZE && tick && run && cnt_r != 9'h001
                                |=> modem_tx_bit == ~$past(cnt_r[0])) // [R23]
    else $error("seizure bit pattern wrong");
  ready_clear_a: assert property (hi_read && !(meter_enable_bit && sample_valid) |=> !meter_result_low[`READY_BIT]) // [R9]
    else $error("ready not cleared by high byte read");
  window_zero_a: assert property (meter_enable_bit && !pll_sleep && sample_valid && window_r == 8'h00 && !rdy_r
                                  |=> meter_result_low[`READY_BIT]) // [R11]
    else $error("direct sample not presented");
  meter_off_a: assert property (!meter_enable_bit && !rdy_r && !hi_read |=> !rdy_r) // [R13]
    else $error("disabled meter produced a result");
  msg_cap_a: assert property (message_length > `MSG_LEN_MAX |-> wl_eff == `MSG_LEN_MAX) // [R24]
    else $error("message length not capped");
endmodule

// File: tb_fsk_meter_loop_control_regs.sv
// Self-checking bench for the modem, meter, loopback and coefficient register bank
`timescale 1ns/1ps
`include "fmlc_consts.svh"
module tb_fsk_meter_loop_control_regs;
  localparam int BC = 4;
  logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, msg_bit = 1'b0, sample_valid = 1'b0;
  logic [7:0] cmd_byte = 8'h00, cmd_wdata = 8'h00, sl = 8'h00, ml = 8'h00, wl = 8'h00, rd;
  logic [1:0] cmd_channel = 2'h0;
  logic [63:0] ch_sample = 64'h0;
  logic rd_valid, msg_bit_take, modem_tx_bit, modem_tx_active, modem_enable_bit, spec_variant_sel;
  logic hold_marking_after_send, modem_transmit_go, meter_enable_bit, meter_mode, pll_sleep, prev_bit;
  logic [1:0] modem_channel_sel, meter_channel;
  logic [7:0] rd_data, meter_result_low, meter_result_high, meter_window_count;
  logic [4:0] loop_enables;
  logic [31:0] coef_source_flat;
  int n_fail = 0, comparisons = 0, rises = 0, takes = 0, i, c;
  fsk_meter_loop_control_regs #(.BIT_CYCLES(BC)) dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .cmd_channel(cmd_channel), .rd_valid(rd_valid),
    .rd_data(rd_data), .seizure_length(sl), .marking_length(ml), .message_length(wl), .msg_bit(msg_bit),
    .msg_bit_take(msg_bit_take), .modem_tx_bit(modem_tx_bit), .modem_tx_active(modem_tx_active),
    .modem_channel_sel(modem_channel_sel), .modem_enable_bit(modem_enable_bit),
    .spec_variant_sel(spec_variant_sel), .hold_marking_after_send(hold_marking_after_send),
    .modem_transmit_go(modem_transmit_go), .sample_valid(sample_valid), .ch_sample(ch_sample),
    .meter_result_low(meter_result_low), .meter_result_high(meter_result_high),
    .meter_window_count(meter_window_count), .meter_enable_bit(meter_enable_bit), .meter_mode(meter_mode),
    .meter_channel(meter_channel), .pll_sleep(pll_sleep), .loop_enables(loop_enables),
    .coef_source_flat(coef_source_flat));
  // ----------------------------------------
  // Clock and bit-stream monitor
  // ----------------------------------------
  // 20 MHz clock
  always #25 clk = ~clk;
  // Counts rising bits while sending, and message bit hand-offs
  always @(posedge clk) begin
    if (modem_tx_active === 1'b1 && modem_tx_bit === 1'b1 && prev_bit === 1'b0) rises++;
    if (msg_bit_take === 1'b1) takes++;
    prev_bit <= modem_tx_bit;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One command; read data is taken in the cycle after the strobe
  task automatic cmd(input logic wr, input logic [6:0] ofs, input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_byte = {wr, ofs};
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    if (!wr) check(rd_valid, 1'b1, "rd_valid");
    rd = rd_data;
    @(negedge clk);
    if (!wr) check(rd_valid, 1'b0, "rd_valid pulse");
  endtask
  task automatic rd_chk(input logic [6:0] ofs, input logic [7:0] exp);
    cmd(1'b0, ofs, 8'h00);
    check(rd, exp, "read data");
  endtask
  task automatic sample(input logic [63:0] s);
    sample_valid = 1'b1;
    ch_sample = s;
    @(negedge clk);
    sample_valid = 1'b0;
    @(negedge clk);
  endtask
  // Coefficient source byte per channel; impedance bits 0 and 2 kept equal
  function automatic logic [7:0] coef_val(input int c);
    coef_val = 8'(8'h30 << c) | (c[1] ? 8'h08 : 8'h00) | (c[0] ? 8'h05 : 8'h00);
  endfunction
  // Starts a send and waits until the go bit drops
  task automatic send(input logic [7:0] s, m, w, input logic hold);
    sl = s;
    ml = m;
    wl = w;
    rises = 0;
    takes = 0;
    cmd(1'b1, `OFS_MODEM_CTRL, {6'h02, hold, 1'b1});
    check(modem_transmit_go, 1'b1, "go set");
    for (i = 0; i < 3000 && modem_transmit_go !== 1'b0; i++) @(negedge clk);
    if (i == 3000) begin
      n_fail++;
      $display("FAIL %0t go never cleared", $time);
      close_out();
    end
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    // Reset values, and unmapped offsets reading zero
    rd_chk(`OFS_COEF_SEL, 8'h00);
    rd_chk(`OFS_MODEM_CTRL, 8'h00);
    rd_chk(`OFS_RESULT_LOW, 8'h00);
    rd_chk(`OFS_RESULT_HIGH, 8'h00);
    rd_chk(`OFS_METER_CTRL, 8'h00);
    rd_chk(`OFS_LOOP_PLL, 8'h00);
    rd_chk(7'h10, 8'h00);
    $display("reset test done");
    // Write and read back, reserved bits dropped, low result byte read-only
    cmd(1'b1, `OFS_MODEM_CTRL, 8'hf6);
    rd_chk(`OFS_MODEM_CTRL, 8'h36);
    check({modem_channel_sel, modem_enable_bit, spec_variant_sel, hold_marking_after_send}, 5'h1b, "fld");
    cmd(1'b1, `OFS_METER_CTRL, 8'hff);
    rd_chk(`OFS_METER_CTRL, 8'h0f);
    check({meter_enable_bit, meter_mode, meter_channel}, 4'hf, "meter fields");
    cmd(1'b1, `OFS_LOOP_PLL, 8'hff);
    rd_chk(`OFS_LOOP_PLL, 8'h3f);
    check({pll_sleep, loop_enables}, 6'h3f, "loop fields");
    cmd(1'b1, `OFS_LOOP_PLL, 8'h12);
    check(loop_enables, 5'h12, "loop bits");
    cmd(1'b1, `OFS_WINDOW, 8'ha5);
    rd_chk(`OFS_WINDOW, 8'ha5);
    check(meter_window_count, 8'ha5, "window");
    cmd(1'b1, `OFS_RESULT_LOW, 8'hff);
    rd_chk(`OFS_RESULT_LOW, 8'h00);
    for (c = 0; c < 4; c++) begin
      cmd_channel = c[1:0];
      cmd(1'b1, `OFS_COEF_SEL, coef_val(c));
      cmd(1'b1, `OFS_MODEM_CTRL, {2'h0, c[1:0], 4'h0});
      check(modem_channel_sel, c[1:0], "modem chan");
      cmd(1'b1, `OFS_METER_CTRL, {6'h00, c[1:0]});
      check(meter_channel, c[1:0], "meter chan");
    end
    for (c = 0; c < 4; c++) begin
      cmd_channel = c[1:0];
      rd_chk(`OFS_COEF_SEL, coef_val(c));
      check(coef_source_flat[8*c+:8], coef_val(c), "coef flat");
    end
    $display("register test done");
    // Modem: all lengths zero, disabled go, seizure pairs, data counts, data cap, hold and restart
    cmd(1'b1, `OFS_MODEM_CTRL, 8'h09);
    check(modem_transmit_go, 1'b0, "go zero lengths");
    sl = 8'h01;
    cmd(1'b1, `OFS_MODEM_CTRL, 8'h01);
    repeat (BC * 3) @(negedge clk);
    check({modem_transmit_go, modem_tx_active}, 2'h0, "go disabled");
    send(8'h02, 8'h00, 8'h00, 1'b0);
    check(rises, 2, "seizure pairs");
    check({modem_tx_active, modem_tx_bit}, 2'h0, "muted");
    send(8'h01, 8'h02, 8'h03, 1'b0);
    check(rises, 1, "seizure one pair");
    check(takes, 3, "data bits");
    send(8'h00, 8'h00, 8'h64, 1'b0);
    check(takes, 64, "data cap");
    send(8'h00, 8'h00, 8'h02, 1'b1);
    check(takes, 2, "held frame");
    repeat (BC * 4) @(negedge clk);
    check({modem_tx_active, modem_tx_bit}, 2'h3, "hold ones");
    send(8'h00, 8'h00, 8'h02, 1'b0);
    check(takes, 2, "restart");
    check({modem_tx_active, modem_tx_bit}, 2'h0, "muted after");
    $display("modem test done");
    // Meter: disabled, window zero in both modes, window of three, sleep
    cmd(1'b1, `OFS_METER_CTRL, 8'h06);
    sample(64'h0000_fed4_0000_0000);
    check(meter_result_low, 8'h00, "disabled");
    cmd(1'b1, `OFS_WINDOW, 8'h00);
    cmd(1'b1, `OFS_METER_CTRL, 8'h0e);
    sample(64'h0000_fed4_0000_0000);
    rd_chk(`OFS_RESULT_LOW, 8'h59);
    sample(64'h0000_7fff_0000_0000);
    rd_chk(`OFS_RESULT_HIGH, 8'h02);
    check(meter_result_low[0], 1'b0, "ready cleared");
    cmd(1'b1, `OFS_METER_CTRL, 8'h09);
    sample(64'h0000_0000_00a7_0000);
    rd_chk(`OFS_RESULT_LOW, 8'h01);
    rd_chk(`OFS_RESULT_HIGH, 8'ha7);
    cmd(1'b1, `OFS_WINDOW, 8'h03);
    cmd(1'b1, `OFS_METER_CTRL, 8'h0d);
    sample(64'h0000_0000_0005_0000);
    sample(64'h0000_0000_ffd8_0000);
    check(meter_result_low[0], 1'b0, "window open");
    sample(64'h0000_0000_0007_0000);
    check({meter_result_high, meter_result_low}, 16'h0051, "window peak");
    rd_chk(`OFS_RESULT_HIGH, 8'h00);
    cmd(1'b1, `OFS_WINDOW, 8'h00);
    cmd(1'b1, `OFS_LOOP_PLL, 8'h20);
    sample(64'h0000_0000_0100_0000);
    check(meter_result_low[0], 1'b0, "sleep");
    $display("meter test done");
    // Reset in mid-run returns written registers to defaults
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd_chk(`OFS_METER_CTRL, 8'h00);
    rd_chk(`OFS_LOOP_PLL, 8'h00);
    check({modem_tx_active, meter_result_low}, 9'h000, "reset again");
    $display("reset again test done");
    close_out();
  end
endmodule
